//--- wdt_consts.vh
// constants shared by the watchdog timer and its prescaler
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define WDT_CNT_W 16
`define WDT_PRE_W 14

// ----------------------------------------------------------------
// prescaler divisions (select 0 = fine, 1 = coarse)
// ----------------------------------------------------------------
`define WDT_DIV_FINE 14'h00FF
`define WDT_DIV_COARSE 14'h3FFF
`define WDT_SEL_FINE 1'b0
`define WDT_SEL_COARSE 1'b1

// ----------------------------------------------------------------
// power-up interval, stated against a 10 MHz reference clock
// ----------------------------------------------------------------
`define WDT_DEFAULT_INTERVAL_NS 6500000
`define WDT_REF_CLK_MHZ 10
`define WDT_FINE_DIV_N 256
// ticks of the fine prescaler that make the default interval, rounded up
`define WDT_DEFAULT_TICKS \
    ((`WDT_DEFAULT_INTERVAL_NS * `WDT_REF_CLK_MHZ / 1000 + `WDT_FINE_DIV_N - 1) / `WDT_FINE_DIV_N)
`define WDT_RESET_SEL 1'b0

// ----------------------------------------------------------------
// gap between prewarning and reset request
// ----------------------------------------------------------------
`define WDT_PREWARN_NS 2560
`define WDT_CLK_MHZ 100
`define WDT_PREWARN_CYCLES (`WDT_PREWARN_NS * `WDT_CLK_MHZ / 1000)
`define WDT_GAP_W 9

`endif

//--- wdt_prescaler.v
// prescaler that turns the system clock into watchdog count ticks
`default_nettype none
`include "wdt_consts.vh"

module wdt_prescaler
(
    // clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // control
    input wire run_in,
    input wire clear_in,
    input wire sel_in,
    // tick
    output reg tick_out
);

    reg [`WDT_PRE_W-1:0] count;
    wire [`WDT_PRE_W-1:0] last;

    // terminal value for the chosen division
    assign last = (sel_in == `WDT_SEL_COARSE) ? `WDT_DIV_COARSE : `WDT_DIV_FINE;

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    // clear beats run so a service always restarts a full period
    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            count <= {`WDT_PRE_W{1'b0}};
            tick_out <= 1'b0;
        end
        else if (clear_in)
        begin
            count <= {`WDT_PRE_W{1'b0}};
            tick_out <= 1'b0;
        end
        else if (run_in)
        begin
            // >= guards against a select change leaving count past last
            if (count >= last)
            begin
                count <= {`WDT_PRE_W{1'b0}};
                tick_out <= 1'b1;
            end
            else
            begin
                count <= count + {{(`WDT_PRE_W-1){1'b0}}, 1'b1};
                tick_out <= 1'b0;
            end
        end
        else
        begin
            tick_out <= 1'b0; // count holds while stopped
        end
    end

endmodule // wdt_prescaler
`default_nettype wire

//--- system_watchdog_timer.v
// fail-safe watchdog timer with prewarning and reset request
`default_nettype none
`include "wdt_consts.vh"

// How it works
// RULE1: comes up enabled and counting after reset
// RULE2: disable stops counting, enable resumes, any time
// RULE3: software services before overflow, else malfunction
// RULE4: overflow gives prewarning first, reset request later
// RULE5: 16-bit counter on tick of clk/16384 or /256
// RULE6: counter loads from reload value register
// RULE7: service reloads counter and clears prescaler together
// RULE8: power-up defaults give 6.5 ms at 10 MHz
// RULE9: count up per tick, overflow on wrap
// RULE10: disabled holds prescaler, counter, no requests
module system_watchdog_timer
(
    // clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // cpu instructions, one-cycle pulses
    input wire service_in,
    input wire disable_in,
    input wire enable_in,
    // reload value register write
    input wire reload_wr_in,
    input wire [`WDT_CNT_W-1:0] reload_data_in,
    input wire prescale_sel_in,
    // to interrupt controller
    output reg prewarn_irq_out,
    // to reset controller
    output reg reset_req_out,
    // status
    output reg enabled_out,
    output reg [`WDT_CNT_W-1:0] count_out,
    output reg [`WDT_CNT_W-1:0] reload_value_out,
    output reg prescale_sel_out
);

    // ------------------------------------------------------------
    // state encoding
    // ------------------------------------------------------------
    localparam [2:0] ST_COUNT = 3'b001;
    localparam [2:0] ST_PREWARN = 3'b010;
    localparam [2:0] ST_RESET = 3'b100;

    // default reload: counter wraps after the default tick count
    localparam [31:0] DEFAULT_RELOAD_WIDE = 32'h00010000 - `WDT_DEFAULT_TICKS;
    localparam [`WDT_CNT_W-1:0] DEFAULT_RELOAD = DEFAULT_RELOAD_WIDE[`WDT_CNT_W-1:0];
    // gap count is computed wide, then cut to the gap counter on purpose
    localparam [31:0] PREWARN_GAP_WIDE = `WDT_PREWARN_CYCLES;
    localparam [`WDT_GAP_W-1:0] PREWARN_GAP = PREWARN_GAP_WIDE[`WDT_GAP_W-1:0];

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg rst_sync_a;
    reg rst_sync_b;
    wire rst_b;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [`WDT_GAP_W-1:0] gap;
    reg [`WDT_GAP_W-1:0] next_gap;
    reg [`WDT_CNT_W-1:0] next_count;
    reg [`WDT_CNT_W-1:0] next_reload;
    reg next_sel;
    reg next_enabled;
    reg next_prewarn;
    reg next_reset_req;
    wire tick;
    wire run;
    wire wrap;
    wire [`WDT_CNT_W:0] count_up;

    // one step up the counter, shared by count and wrap detect
    function [`WDT_CNT_W:0] step_up;
        input [`WDT_CNT_W-1:0] value;
        begin
            step_up = {1'b0, value} + {{`WDT_CNT_W{1'b0}}, 1'b1};
        end
    endfunction

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // assert at once, release through two flops to avoid metastable exit
    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_sync_a <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_sync_a <= 1'b1;
            rst_sync_b <= rst_sync_a;
        end
    end

    assign rst_b = rst_sync_b;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    // prescaler runs only while counting; gap wait uses raw clock
    assign run = enabled_out && (state == ST_COUNT); // [RULE10]

    wdt_prescaler u_prescaler
    (
        .clk_in(clk_in),
        .rst_b_in(rst_b),
        .run_in(run),
        .clear_in(service_in), // [RULE7]
        .sel_in(prescale_sel_out), // [RULE5]
        .tick_out(tick)
    );

    // all ones plus one carries out of the counter
    assign count_up = step_up(count_out);
    assign wrap = count_up[`WDT_CNT_W]; // [RULE9]

    // ------------------------------------------------------------
    // reload value register and division select
    // ------------------------------------------------------------
    always @*
    begin
        next_reload = reload_value_out;
        next_sel = prescale_sel_out;
        if (reload_wr_in)
        begin
            next_reload = reload_data_in; // [RULE6]
            next_sel = prescale_sel_in; // [RULE5]
        end
    end

    // ------------------------------------------------------------
    // enable control
    // ------------------------------------------------------------
    // enable wins a same-cycle clash: fail-safe side keeps watching
    always @*
    begin
        next_enabled = enabled_out;
        if (enable_in)
        begin
            next_enabled = 1'b1; // [RULE2]
        end
        else if (disable_in)
        begin
            next_enabled = 1'b0; // [RULE2]
        end
    end

    // ------------------------------------------------------------
    // counter and sequence control
    // ------------------------------------------------------------
    // service takes priority over a tick in the same cycle, so the
    // counter restarts from the (possibly just written) reload value
    always @*
    begin
        next_state = state;
        next_count = count_out;
        next_gap = gap;
        next_prewarn = 1'b0;
        next_reset_req = reset_req_out;
        case (state)
            ST_COUNT:
            begin
                if (service_in)
                begin
                    next_count = next_reload; // [RULE7]
                end
                else if (run && tick)
                begin
                    next_count = count_up[`WDT_CNT_W-1:0]; // [RULE9]
                    if (wrap)
                    begin
                        // overflow: warn first, reset later
                        next_prewarn = 1'b1; // [RULE4]
                        next_gap = PREWARN_GAP;
                        next_state = ST_PREWARN;
                    end
                end
            end
            ST_PREWARN:
            begin
                // a late service still rescues the system here
                if (service_in)
                begin
                    next_count = next_reload; // [RULE7]
                    next_state = ST_COUNT;
                end
                else if (enabled_out)
                begin
                    if (gap == {`WDT_GAP_W{1'b0}})
                    begin
                        next_reset_req = 1'b1; // [RULE4]
                        next_state = ST_RESET;
                    end
                    else
                    begin
                        next_gap = gap - {{(`WDT_GAP_W-1){1'b0}}, 1'b1};
                    end
                end
            end
            ST_RESET:
            begin
                // held until the reset controller resets the block
                next_reset_req = 1'b1;
            end
            default:
            begin
                next_state = ST_COUNT;
                next_count = next_reload;
                next_reset_req = 1'b0;
            end
        endcase
        // nothing new is raised while stopped
        if (!enabled_out)
        begin
            next_prewarn = 1'b0; // [RULE10]
        end
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    // reset values start the watchdog with no software help
    always @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ST_COUNT;
            enabled_out <= 1'b1; // [RULE1]
            count_out <= DEFAULT_RELOAD; // [RULE8]
            reload_value_out <= DEFAULT_RELOAD; // [RULE8]
            prescale_sel_out <= `WDT_RESET_SEL; // [RULE8]
            gap <= {`WDT_GAP_W{1'b0}};
            prewarn_irq_out <= 1'b0;
            reset_req_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            enabled_out <= next_enabled;
            count_out <= next_count;
            reload_value_out <= next_reload;
            prescale_sel_out <= next_sel;
            gap <= next_gap;
            prewarn_irq_out <= next_prewarn;
            reset_req_out <= next_reset_req;
        end
    end

endmodule // system_watchdog_timer
`default_nettype wire

//--- wdt_assertions.sv
// checker for the watchdog timer ports
`default_nettype none
module wdt_assertions
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // instructions and reload write
    input wire logic service_in,
    input wire logic disable_in,
    input wire logic enable_in,
    input wire logic reload_wr_in,
    input wire logic [15:0] reload_data_in,
    input wire logic prescale_sel_in,
    // requests and status
    input wire logic prewarn_irq_out,
    input wire logic reset_req_out,
    input wire logic enabled_out,
    input wire logic [15:0] count_out,
    input wire logic [15:0] reload_value_out,
    input wire logic prescale_sel_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic [1:0] up_cnt;
    logic warned;
    wire up = (up_cnt == 2'h3);
    // inputs count only once the synced reset copy has let go
    always_ff @(posedge clk_in or negedge rst_b_in)
        if (!rst_b_in)
            up_cnt <= 2'h0;
        else if (!up)
            up_cnt <= up_cnt + 2'h1;
    // a reset request is only legal after an unanswered prewarning
    always_ff @(posedge clk_in or negedge rst_b_in)
        if (!rst_b_in)
            warned <= 1'b0;
        else if (prewarn_irq_out)
            warned <= 1'b1;
        else if (service_in)
            warned <= 1'b0;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_service_load:
        assert property (up && service_in && !reload_wr_in && !reset_req_out
            |=> count_out == $past(reload_value_out)) else $error("no reload");
    a_write_load:
        assert property (up && service_in && reload_wr_in && !reset_req_out
            |=> count_out == $past(reload_data_in)) else $error("no new reload");
    a_disable_stop:
        assert property (up && disable_in && !enable_in |=> !enabled_out)
            else $error("disable ignored");
    a_enable_run:
        assert property (up && enable_in |=> enabled_out) else $error("enable ignored");
    a_idle_hold:
        assert property (!enabled_out && !enable_in && !service_in
            |=> $stable(count_out) && !prewarn_irq_out) else $error("idle moved");
    a_step_one:
        assert property (up && !service_in && !reset_req_out |=> count_out ==
            $past(count_out) || count_out == $past(count_out) + 16'h1) else $error("bad step");
    a_warn_wrap:
        assert property ($rose(prewarn_irq_out) |-> $past(count_out) == 16'hFFFF
            || $past(count_out, 2) == 16'hFFFF) else $error("warn without wrap");
    a_warn_pulse:
        assert property (prewarn_irq_out |=> !prewarn_irq_out) else $error("long warn");
    a_req_order:
        assert property ($rose(reset_req_out) |-> warned) else $error("request before warn");
    a_req_hold:
        assert property (reset_req_out |=> reset_req_out) else $error("request dropped");
endmodule // wdt_assertions
`default_nettype wire

//--- wdt_partner.sv
// interrupt and reset controller model facing the watchdog
`default_nettype none
module wdt_partner
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // watchdog requests
    input wire logic prewarn_irq_in,
    input wire logic reset_req_in,
    // what the controllers took
    output var logic [7:0] irq_count_out,
    output var logic reset_taken_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // counts every sampled pulse, so a stretched pulse shows as extra
    always_ff @(posedge clk_in or negedge rst_b_in)
        if (!rst_b_in)
            irq_count_out <= 8'h00;
        else if (prewarn_irq_in)
            irq_count_out <= irq_count_out + 8'h01;
    // reset controller latches the request until reset is applied
    always_ff @(posedge clk_in or negedge rst_b_in)
        if (!rst_b_in)
            reset_taken_out <= 1'b0;
        else if (reset_req_in)
            reset_taken_out <= 1'b1;
endmodule // wdt_partner
`default_nettype wire

//--- system_watchdog_timer_tb.sv
// self-checking bench for the watchdog timer
`default_nettype none
module system_watchdog_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rst_b_in, srv, dis, en, wr, sel;
    logic [15:0] data;
    wire pw, rq, ena, ps, tk;
    wire [15:0] cnt, rel;
    wire [7:0] irqs;
    int fails = 0;
    int total_checks = 0;
    system_watchdog_timer uut
    (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .service_in(srv), .disable_in(dis),
        .enable_in(en), .reload_wr_in(wr), .reload_data_in(data), .prescale_sel_in(sel),
        .prewarn_irq_out(pw), .reset_req_out(rq), .enabled_out(ena), .count_out(cnt),
        .reload_value_out(rel), .prescale_sel_out(ps)
    );
    wdt_partner ctl
    (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .prewarn_irq_in(pw), .reset_req_in(rq),
        .irq_count_out(irqs), .reset_taken_out(tk)
    );
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic stop_test();
        if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic in_range(input string what, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi)
        begin
            fails++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    // inputs always move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic cmd(input logic [3:0] m);
        {srv, dis, en, wr} = m;
        tick(1);
        {srv, dis, en, wr} = 4'h0;
        tick(1); // idle edge so a following pulse never rewrites in this step
    endtask
    task automatic wait_on(input bit req, input int lim, output int n);
        for (n = 1; n <= lim; n++)
        begin
            tick(1);
            if ((req ? rq : pw) === 1'b1)
                return;
        end
        fails++;
        $display("[FAIL] wait expected event seen none");
        stop_test();
    endtask
    task automatic do_reset();
        rst_b_in = 1'b0;
        tick(4);
        rst_b_in = 1'b1;
        tick(3);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_power_up();
        int n;
        do_reset();
        chk("enabled", 16'h1, {15'h0, ena});
        chk("reload", 16'hFF02, rel);
        chk("select", 16'h0, {15'h0, ps});
        wait_on(1'b0, 70000, n);
        in_range("interval", 65018, 65030, n);
        wait_on(1'b1, 300, n);
        in_range("gap", 255, 259, n);
        // controllers register what they saw one edge later
        tick(1);
        chk("irqs", 16'h1, {8'h0, irqs});
        chk("taken", 16'h1, {15'h0, tk});
    endtask
    task automatic t_service();
        int n;
        do_reset();
        data = 16'hFFF0;
        cmd(4'h1);
        chk("reload", 16'hFFF0, rel);
        tick(200);
        cmd(4'h8);
        chk("count", 16'hFFF0, cnt);
        tick(250);
        chk("cleared", 16'hFFF0, cnt);
        wait_on(1'b0, 5000, n);
        in_range("interval", 3840, 3852, n);
        tick(10);
        cmd(4'h8);
        tick(300);
        chk("request", 16'h0, {15'h0, rq});
    endtask
    task automatic t_disable();
        logic [15:0] c;
        int n;
        data = 16'hFFFE;
        cmd(4'h9);
        chk("count", 16'hFFFE, cnt);
        cmd(4'h4);
        chk("enabled", 16'h0, {15'h0, ena});
        c = cnt;
        tick(600);
        chk("held", c, cnt);
        chk("irqs", 16'h1, {8'h0, irqs});
        // both at once: enable takes precedence
        cmd(4'h6);
        chk("enabled", 16'h1, {15'h0, ena});
        wait_on(1'b0, 600, n);
        in_range("resume", 505, 515, n);
    endtask
    task automatic t_coarse();
        int n;
        do_reset();
        data = 16'hFFFF;
        sel = 1'b1;
        cmd(4'h9);
        chk("select", 16'h1, {15'h0, ps});
        wait_on(1'b0, 17000, n);
        in_range("coarse", 16380, 16390, n);
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial
    begin
        {srv, dis, en, wr, sel} = 5'h00;
        data = 16'h0000;
        t_power_up();
        t_service();
        t_disable();
        t_coarse();
        stop_test();
    end
endmodule // system_watchdog_timer_tb
bind system_watchdog_timer wdt_assertions chk_i
(
    .clk_in(clk_in), .rst_b_in(rst_b_in), .service_in(service_in),
    .disable_in(disable_in), .enable_in(enable_in), .reload_wr_in(reload_wr_in),
    .reload_data_in(reload_data_in), .prescale_sel_in(prescale_sel_in),
    .prewarn_irq_out(prewarn_irq_out), .reset_req_out(reset_req_out),
    .enabled_out(enabled_out), .count_out(count_out),
    .reload_value_out(reload_value_out), .prescale_sel_out(prescale_sel_out)
);
`default_nettype wire
